// ### src/smgc_top.sv
// Switch MAC global control bank: registers, frame verdict, storm limiter.
// Assumes an AXI4-Lite master and a datapath that presents one frame a cycle.
`include "smgc_defs.svh"
module smgc_top import smgc_pkg::*; #(
	parameter int STORM_1G_CYC = `SMGC_STORM_1G_US * 1000 / `SMGC_CLK_NS,
	parameter int INGR_UNIT_CYC = `SMGC_INGR_16_US * 1000 / `SMGC_CLK_NS
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic [11:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [11:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic frm_valid_in,
	input wire logic [2:0] frm_port_in,
	input wire logic [13:0] frm_len_in,
	input wire logic frm_tagged_in,
	input wire logic frm_bcast_in,
	input wire logic frm_mcast_in,
	input wire logic frm_pause_in,
	input wire logic [11:0] frm_vid_in,
	input wire logic [2:0] frm_pcp_in,
	input wire logic [11:0] frm_pvid_in,
	input wire logic [13:0] jumbo_limit_in,
	input wire logic [15:0] port_speed_in,
	input wire logic col_valid_in,
	input wire logic [4:0] col_count_in,
	output logic vrd_valid_out,
	output logic vrd_accept_out,
	output logic vrd_storm_drop_out,
	output logic [11:0] vrd_vid_out,
	output logic [2:0] vrd_prio_out,
	output logic col_discard_out,
	output logic bp_carrier_sense_out,
	output logic fair_mode_out,
	output logic no_xcol_drop_out,
	output logic egr_per_queue_out,
	output logic mib_flush_out,
	output logic mib_freeze_out,
	output logic ingr_tick_out
);
	// ****************************************
	// Constants and functions
	// ****************************************
	localparam logic [3:0] S_C1 = 4'(`SMGC_IDX_CTRL1 - `SMGC_IDX_CTRL1);
	localparam logic [3:0] S_C2 = 4'(`SMGC_IDX_CTRL2 - `SMGC_IDX_CTRL1);
	localparam logic [3:0] S_C3 = 4'(`SMGC_IDX_CTRL3 - `SMGC_IDX_CTRL1);
	localparam logic [3:0] S_C4 = 4'(`SMGC_IDX_CTRL4 - `SMGC_IDX_CTRL1);
	localparam logic [3:0] S_C5 = 4'(`SMGC_IDX_CTRL5 - `SMGC_IDX_CTRL1);
	localparam logic [3:0] S_MIB = 4'(`SMGC_IDX_MIB - `SMGC_IDX_CTRL1);
	localparam logic [3:0] S_MAP0 = 4'(`SMGC_IDX_MAP0 - `SMGC_IDX_CTRL1);
	localparam logic [3:0] S_LAST = 4'(`SMGC_IDX_MAP3 - `SMGC_IDX_CTRL1);
	localparam logic [3:0] DEC_LAST = 4'(`SMGC_STORM_100M_US / `SMGC_STORM_1G_US - 1);
	localparam logic [4:0] U64 = 5'(`SMGC_INGR_64_US / `SMGC_INGR_16_US);
	localparam logic [4:0] U256 = 5'(`SMGC_INGR_256_US / `SMGC_INGR_16_US);

	// Returns {valid, slot}; the hole and out-of-bank words are invalid
	function automatic logic [4:0] smgc_slot(input logic [11:0] a);
		logic [9:0] d;
		d = a[11:2] - `SMGC_IDX_CTRL1;
		smgc_slot = {(d <= 10'(S_LAST)) && (a[11:2] != `SMGC_IDX_HOLE), d[3:0]};
	endfunction : smgc_slot

	function automatic logic [7:0] smgc_rst(input logic [3:0] s);
		case (s)
			S_C1: smgc_rst = `SMGC_RST_CTRL1;
			S_C3: smgc_rst = `SMGC_RST_CTRL3;
			S_C5: smgc_rst = `SMGC_RST_CTRL5;
			S_MAP0: smgc_rst = `SMGC_RST_MAP0;
			S_MAP0 + 4'h1: smgc_rst = `SMGC_RST_MAP1;
			S_MAP0 + 4'h2: smgc_rst = `SMGC_RST_MAP2;
			S_LAST: smgc_rst = `SMGC_RST_MAP3;
			default: smgc_rst = 8'h00;
		endcase
	endfunction : smgc_rst

	// Read-only bits never take a write, so they always read their reset value
	function automatic logic [7:0] smgc_wmask(input logic [3:0] s);
		case (s)
			S_C1, S_C2, S_C3: smgc_wmask = 8'hFF;
			S_C4: smgc_wmask = `SMGC_WM_CTRL4;
			S_C5: smgc_wmask = `SMGC_WM_CTRL5;
			S_MIB: smgc_wmask = `SMGC_WM_MIB;
			S_MAP0, S_MAP0 + 4'h1, S_MAP0 + 4'h2, S_LAST: smgc_wmask = `SMGC_WM_MAP;
			default: smgc_wmask = 8'h00;
		endcase
	endfunction : smgc_wmask

	function automatic logic smgc_port_tick(input logic [1:0] spd, input logic t1g, input logic t100,
		input logic t10);
		case (smgc_speed_t'(spd))
			SMGC_SPD_1G: smgc_port_tick = t1g;
			SMGC_SPD_100: smgc_port_tick = t100;
			default: smgc_port_tick = t10;
		endcase
	endfunction : smgc_port_tick

	// ****************************************
	// Signals
	// ****************************************
	smgc_st_t st_r;
	smgc_st_t st_nxt;
	logic aw_fire;
	logic w_fire;
	logic ar_fire;
	logic wr_go;
	logic [4:0] wsel;
	logic [4:0] rsel;
	logic t1g;
	logic t100;
	logic t10;
	logic storm_cls;
	logic storm_hit;
	logic [16:0] allow;
	logic [16:0] base;
	logic [17:0] need;
	logic [4:0] units;
	logic size_ok;
	logic pause_ok;
	logic [11:0] vid_c;
	logic [2:0] prio_c;

	assign aw_fire = s_axi_awvalid_in && st_r.awready;
	assign w_fire = s_axi_wvalid_in && st_r.wready;
	assign ar_fire = s_axi_arvalid_in && st_r.arready;
	assign wr_go = st_r.aw_held && st_r.w_held && !st_r.bvalid;
	assign wsel = smgc_slot(st_r.awaddr);
	assign rsel = smgc_slot(s_axi_araddr_in);

	smgc_frame_check u_check (
		.ctrl1_in(st_r.regs[S_C1]),
		.ctrl2_in(st_r.regs[S_C2]),
		.ctrl4_in(st_r.regs[S_C4]),
		.map_in(st_r.regs[S_LAST:S_MAP0]),
		.len_in(frm_len_in),
		.tagged_in(frm_tagged_in),
		.pause_in(frm_pause_in),
		.vid_in(frm_vid_in),
		.pcp_in(frm_pcp_in),
		.pvid_in(frm_pvid_in),
		.jumbo_limit_in(jumbo_limit_in),
		.size_ok_out(size_ok),
		.pause_ok_out(pause_ok),
		.vid_out(vid_c),
		.prio_out(prio_c)
	);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		st_nxt = st_r;
		st_nxt.mib_flush = 1'b0;
		st_nxt.col_discard = 1'b0;
		st_nxt.vrd_valid = 1'b0;
		st_nxt.ingr_tick = 1'b0;
		// Storm period timebase: 100M and 10M periods are decades of 1G
		t1g = st_r.cnt_1g == 28'(STORM_1G_CYC - 1);
		t100 = t1g && (st_r.dec1 == DEC_LAST);
		t10 = t100 && (st_r.dec2 == DEC_LAST);
		st_nxt.cnt_1g = t1g ? 28'h0000000 : st_r.cnt_1g + 28'h0000001;
		if (t1g) begin
			st_nxt.dec1 = (st_r.dec1 == DEC_LAST) ? 4'h0 : st_r.dec1 + 4'h1;
		end
		if (t100) begin
			st_nxt.dec2 = (st_r.dec2 == DEC_LAST) ? 4'h0 : st_r.dec2 + 4'h1;
		end
		for (int p = 0; p < 8; p++) begin
			if (smgc_port_tick(port_speed_in[2 * p +: 2], t1g, t100, t10)) begin
				st_nxt.used[p] = 17'h00000;
			end
		end
		// Storm limiter on the frame's ingress port
		allow = {st_r.regs[S_C2][2:0], st_r.regs[S_C3], 6'h00} >> (6 - `SMGC_STORM_SHIFT);
		base = smgc_port_tick(port_speed_in[2 * frm_port_in +: 2], t1g, t100, t10) ? 17'h00000
			: st_r.used[frm_port_in];
		need = {1'b0, base} + {4'h0, frm_len_in};
		storm_cls = frm_bcast_in || (frm_mcast_in && !st_r.regs[S_C1][`SMGC_B_MC_EXCL]);
		storm_hit = size_ok && pause_ok && storm_cls && (need > {1'b0, allow});
		if (frm_valid_in) begin
			st_nxt.vrd_valid = 1'b1;
			st_nxt.vrd_accept = size_ok && pause_ok && !storm_hit;
			st_nxt.vrd_storm = storm_hit;
			st_nxt.vrd_vid = vid_c;
			st_nxt.vrd_prio = prio_c;
			if (size_ok && pause_ok && storm_cls && !storm_hit) begin
				st_nxt.used[frm_port_in] = need[16:0];
			end
		end
		// Excessive collisions
		if (col_valid_in && (col_count_in >= `SMGC_XCOL)) begin
			st_nxt.col_discard = !st_r.regs[S_C1][`SMGC_B_NO_XCOL];
		end
		// Ingress rate-limit period in 16 ms units
		case (st_r.regs[S_C5][`SMGC_B_INGR_HI:`SMGC_B_INGR_LO])
			2'b00: units = 5'h01;
			2'b01: units = U64;
			default: units = U256;
		endcase
		st_nxt.ingr_cnt = st_r.ingr_cnt + 28'h0000001;
		if (st_r.ingr_cnt >= 28'(INGR_UNIT_CYC - 1)) begin
			st_nxt.ingr_cnt = 28'h0000000;
			st_nxt.ingr_unit = st_r.ingr_unit + 5'h01;
			// Shrinking the period below the units already counted ends the current one at the next 16 ms unit boundary
			if (st_r.ingr_unit >= units - 5'h01) begin
				st_nxt.ingr_unit = 5'h00;
				st_nxt.ingr_tick = 1'b1;
			end
		end
		// Write channel
		if (aw_fire) begin
			st_nxt.aw_held = 1'b1;
			st_nxt.awaddr = s_axi_awaddr_in;
		end
		if (w_fire) begin
			st_nxt.w_held = 1'b1;
			st_nxt.wdata = s_axi_wdata_in[7:0];
			st_nxt.wstb = s_axi_wstrb_in[0];
		end
		if (wr_go) begin
			st_nxt.aw_held = 1'b0;
			st_nxt.w_held = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = wsel[4] ? SMGC_OKAY : SMGC_SLVERR;
			if (wsel[4] && st_r.wstb) begin
				st_nxt.regs[wsel[3:0]] = (st_r.regs[wsel[3:0]] & ~smgc_wmask(wsel[3:0]))
					| (st_r.wdata & smgc_wmask(wsel[3:0]));
				st_nxt.mib_flush = (wsel[3:0] == S_MIB) && st_r.wdata[`SMGC_B_MIB_FLUSH];
			end
		end
		st_nxt.regs[S_MIB][`SMGC_B_MIB_FLUSH] = 1'b0;
		if (st_r.bvalid && s_axi_bready_in) begin
			st_nxt.bvalid = 1'b0;
		end
		// Read channel
		if (st_r.rvalid && s_axi_rready_in) begin
			st_nxt.rvalid = 1'b0;
		end
		if (ar_fire) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp = rsel[4] ? SMGC_OKAY : SMGC_SLVERR;
			st_nxt.rdata = rsel[4] ? st_r.regs[rsel[3:0]] : 8'h00;
		end
		// One write and one read in flight at a time
		st_nxt.awready = !st_nxt.aw_held && !st_nxt.bvalid;
		st_nxt.wready = !st_nxt.w_held && !st_nxt.bvalid;
		st_nxt.arready = !st_nxt.rvalid;
		if (rst_in) begin
			st_nxt = '0;
			for (int i = 0; i <= int'(S_LAST); i++) begin
				st_nxt.regs[i] = smgc_rst(4'(i));
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		st_r <= st_nxt;
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign s_axi_awready_out = st_r.awready;
	assign s_axi_wready_out = st_r.wready;
	assign s_axi_bvalid_out = st_r.bvalid;
	assign s_axi_bresp_out = st_r.bresp;
	assign s_axi_arready_out = st_r.arready;
	assign s_axi_rvalid_out = st_r.rvalid;
	assign s_axi_rresp_out = st_r.rresp;
	assign s_axi_rdata_out = {24'h000000, st_r.rdata};
	assign vrd_valid_out = st_r.vrd_valid;
	assign vrd_accept_out = st_r.vrd_accept;
	assign vrd_storm_drop_out = st_r.vrd_storm;
	assign vrd_vid_out = st_r.vrd_vid;
	assign vrd_prio_out = st_r.vrd_prio;
	assign col_discard_out = st_r.col_discard;
	assign bp_carrier_sense_out = st_r.regs[S_C1][`SMGC_B_BP_CS];
	assign fair_mode_out = st_r.regs[S_C1][`SMGC_B_FAIR];
	// Alternate back-off lives outside this bank; software pairs it with this bit
	assign no_xcol_drop_out = st_r.regs[S_C1][`SMGC_B_NO_XCOL];
	assign egr_per_queue_out = st_r.regs[S_C5][`SMGC_B_EGR_QUEUE];
	assign mib_flush_out = st_r.mib_flush;
	assign mib_freeze_out = st_r.regs[S_MIB][`SMGC_B_MIB_FREEZE];
	assign ingr_tick_out = st_r.ingr_tick;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);

	sequence s_both_held;
		st_r.aw_held && st_r.w_held && !st_r.bvalid;
	endsequence
	sequence s_flush_wr;
		wr_go && wsel == {1'b1, S_MIB} && st_r.wstb && st_r.wdata[`SMGC_B_MIB_FLUSH];
	endsequence

	AST_WR_RESP: assert property (s_both_held |=> s_axi_bvalid_out && !s_axi_awready_out)
		else $error("write response missing");
	AST_FLUSH: assert property (s_flush_wr |=> mib_flush_out ##1 !mib_flush_out)
		else $error("flush not a single pulse");
	AST_FREEZE: assert property (wr_go && wsel == {1'b1, S_MIB} && st_r.wstb
		|=> mib_freeze_out == $past(st_r.wdata[`SMGC_B_MIB_FREEZE]))
		else $error("freeze bit not taken");
	AST_OVERSIZE: assert property (frm_valid_in && !st_r.regs[S_C1][`SMGC_B_JUMBO]
		&& !st_r.regs[S_C1][`SMGC_B_LEGAL_DIS] && frm_len_in > `SMGC_LEN_TAG
		|=> vrd_valid_out && !vrd_accept_out)
		else $error("oversize frame accepted");
	AST_LEGAL: assert property (frm_valid_in && !st_r.regs[S_C1][`SMGC_B_JUMBO]
		&& st_r.regs[S_C1][`SMGC_B_LEGAL_DIS] && frm_len_in > `SMGC_LEN_TAG
		&& frm_len_in <= `SMGC_LEN_LEGAL_DIS && !frm_pause_in && !storm_cls |=> vrd_accept_out)
		else $error("2000 byte frame dropped");
	AST_SHORT: assert property (frm_valid_in && frm_len_in < `SMGC_LEN_MIN
		&& !st_r.regs[S_C1][`SMGC_B_PASS_SHORT] |=> !vrd_accept_out)
		else $error("short frame accepted");
	AST_VID: assert property (frm_valid_in && st_r.regs[S_C2][`SMGC_B_NULL_VID]
		&& frm_vid_in == 12'h000 |=> vrd_vid_out == $past(frm_pvid_in))
		else $error("null vid not replaced");
	AST_PAUSE: assert property (frm_valid_in && frm_pause_in
		&& !st_r.regs[S_C4][`SMGC_B_PASS_PAUSE] |=> vrd_valid_out && !vrd_accept_out)
		else $error("pause frame forwarded");
	AST_COLL: assert property (col_valid_in && col_count_in >= `SMGC_XCOL
		|=> col_discard_out != $past(st_r.regs[S_C1][`SMGC_B_NO_XCOL]))
		else $error("collision drop wrong");
	AST_MC_EXCL: assert property (frm_valid_in && frm_mcast_in && !frm_bcast_in
		&& st_r.regs[S_C1][`SMGC_B_MC_EXCL] |=> !vrd_storm_drop_out)
		else $error("multicast counted as storm");
	AST_STORM_RESTART: assert property (t1g && port_speed_in[7:6] == SMGC_SPD_1G && !frm_valid_in
		|=> st_r.used[3] == 17'h00000)
		else $error("storm allowance not restarted");
endmodule : smgc_top

// ### src/smgc_defs.svh
// Offsets, field positions, reset values and timing counts of the bank.
// Assumes a 125 MHz system clock.
`ifndef SMGC_DEFS_SVH
`define SMGC_DEFS_SVH
`define SMGC_CLK_NS 8
// Register indices; byte address is four times the index
`define SMGC_IDX_CTRL1 10'h331
`define SMGC_IDX_CTRL2 10'h332
`define SMGC_IDX_CTRL3 10'h333
`define SMGC_IDX_CTRL4 10'h334
`define SMGC_IDX_CTRL5 10'h335
`define SMGC_IDX_MIB 10'h336
`define SMGC_IDX_HOLE 10'h337
`define SMGC_IDX_MAP0 10'h338
`define SMGC_IDX_MAP1 10'h339
`define SMGC_IDX_MAP2 10'h33A
`define SMGC_IDX_MAP3 10'h33B
`define SMGC_RST_CTRL1 8'hF0
`define SMGC_RST_CTRL3 8'h4A
`define SMGC_RST_CTRL5 8'h10
`define SMGC_RST_MAP0 8'h10
`define SMGC_RST_MAP1 8'h32
`define SMGC_RST_MAP2 8'h54
`define SMGC_RST_MAP3 8'h76
`define SMGC_WM_CTRL4 8'h01
`define SMGC_WM_CTRL5 8'h78
`define SMGC_WM_MIB 8'hC0
`define SMGC_WM_MAP 8'h77
// Field positions
`define SMGC_B_MC_EXCL 6
`define SMGC_B_BP_CS 5
`define SMGC_B_FAIR 4
`define SMGC_B_NO_XCOL 3
`define SMGC_B_JUMBO 2
`define SMGC_B_LEGAL_DIS 1
`define SMGC_B_PASS_SHORT 0
`define SMGC_B_NULL_VID 3
`define SMGC_B_PASS_PAUSE 0
`define SMGC_B_INGR_HI 5
`define SMGC_B_INGR_LO 4
`define SMGC_B_EGR_QUEUE 3
`define SMGC_B_MIB_FLUSH 7
`define SMGC_B_MIB_FREEZE 6
// Frame sizes in bytes, then the excessive collision count and the storm allowance shift
`define SMGC_LEN_SHORT 14'd32
`define SMGC_LEN_MIN 14'd64
`define SMGC_LEN_UNTAG 14'd1518
`define SMGC_LEN_TAG 14'd1522
`define SMGC_LEN_LEGAL_DIS 14'd2000
`define SMGC_LEN_JUMBO 14'd9000
`define SMGC_XCOL 5'd16
`define SMGC_STORM_SHIFT 6
// Periods in microseconds
`define SMGC_STORM_1G_US 5000
`define SMGC_STORM_100M_US 50000
`define SMGC_INGR_16_US 16000
`define SMGC_INGR_64_US 64000
`define SMGC_INGR_256_US 256000
`endif

// ### src/smgc_pkg.sv
// Types shared by the switch MAC global control bank.
// Assumes smgc_defs.svh is on the include path.
package smgc_pkg;
	typedef enum logic [1:0] {
		SMGC_SPD_10 = 2'b00,
		SMGC_SPD_100 = 2'b01,
		SMGC_SPD_1G = 2'b10
	} smgc_speed_t;
	typedef enum logic [1:0] {
		SMGC_OKAY = 2'b00,
		SMGC_SLVERR = 2'b10
	} smgc_resp_t;
	typedef struct packed {
		logic [10:0][7:0] regs;
		logic aw_held;
		logic [11:0] awaddr;
		logic w_held;
		logic [7:0] wdata;
		logic wstb;
		logic awready;
		logic wready;
		logic bvalid;
		smgc_resp_t bresp;
		logic arready;
		logic rvalid;
		smgc_resp_t rresp;
		logic [7:0] rdata;
		logic vrd_valid;
		logic vrd_accept;
		logic vrd_storm;
		logic [11:0] vrd_vid;
		logic [2:0] vrd_prio;
		logic col_discard;
		logic mib_flush;
		logic [27:0] cnt_1g;
		logic [3:0] dec1;
		logic [3:0] dec2;
		logic [27:0] ingr_cnt;
		logic [4:0] ingr_unit;
		logic ingr_tick;
		logic [7:0][16:0] used;
	} smgc_st_t;
endpackage : smgc_pkg

// ### src/smgc_frame_check.sv
// Size admission, PAUSE filter, null VID replacement and PCP lookup.
// Assumes control bytes come straight from the register bank.
`include "smgc_defs.svh"
module smgc_frame_check import smgc_pkg::*; (
	input wire logic [7:0] ctrl1_in,
	input wire logic [7:0] ctrl2_in,
	input wire logic [7:0] ctrl4_in,
	input wire logic [31:0] map_in,
	input wire logic [13:0] len_in,
	input wire logic tagged_in,
	input wire logic pause_in,
	input wire logic [11:0] vid_in,
	input wire logic [2:0] pcp_in,
	input wire logic [11:0] pvid_in,
	input wire logic [13:0] jumbo_limit_in,
	output logic size_ok_out,
	output logic pause_ok_out,
	output logic [11:0] vid_out,
	output logic [2:0] prio_out
);
	logic [13:0] max_len;
	logic [13:0] min_len;

	always_comb begin
		// Jumbo overrides the legal size check disable
		if (ctrl1_in[`SMGC_B_JUMBO]) begin
			max_len = (jumbo_limit_in > `SMGC_LEN_JUMBO) ? `SMGC_LEN_JUMBO : jumbo_limit_in;
		end else if (ctrl1_in[`SMGC_B_LEGAL_DIS]) begin
			max_len = `SMGC_LEN_LEGAL_DIS;
		end else begin
			max_len = tagged_in ? `SMGC_LEN_TAG : `SMGC_LEN_UNTAG;
		end
		min_len = ctrl1_in[`SMGC_B_PASS_SHORT] ? `SMGC_LEN_SHORT : `SMGC_LEN_MIN;
		size_ok_out = (len_in >= min_len) && (len_in <= max_len);
		pause_ok_out = !pause_in || ctrl4_in[`SMGC_B_PASS_PAUSE];
		if (ctrl2_in[`SMGC_B_NULL_VID] && (vid_in == 12'h000)) begin
			vid_out = pvid_in;
		end else begin
			vid_out = vid_in;
		end
		// Entry for PCP p sits at bit 4p: even low nibble, odd high
		prio_out = map_in[{pcp_in, 2'b00} +: 3];
	end
endmodule : smgc_frame_check

// ### verif/switch_mac_global_control_tb_top.sv
// Self-checking bench for the switch MAC global control bank, with a behavioural model.
// Assumes smgc_top with shortened storm and ingress periods, reached over AXI4-Lite.
`include "smgc_defs.svh"
module switch_mac_global_control_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ****************
	// Signals and model
	// ****************
	localparam logic [7:0] RV [11] = '{8'hF0, 8'h00, 8'h4A, 8'h00, 8'h10, 8'h00, 8'h00, 8'h10, 8'h32, 8'h54, 8'h76};
	localparam logic [7:0] WM [11] = '{8'hFF, 8'hFF, 8'hFF, 8'h01, 8'h78, 8'h40, 8'h00, 8'h77, 8'h77, 8'h77, 8'h77};
	localparam int LT [12] = '{31, 32, 63, 64, 1518, 1519, 1522, 1523, 2000, 2001, 9000, 9001};
	localparam logic [4:0] CL [3] = '{5'h0F, 5'h10, 5'h1F};
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0, fv = 1'b0, cv = 1'b0;
	logic ft = 1'b0, fb = 1'b0, fm = 1'b0, fpa = 1'b0;
	logic [11:0] awa = 12'h000, ara = 12'h000, fvid = 12'h000, fpv = 12'h000;
	logic [31:0] wd = 32'h00000000;
	logic [2:0] fp = 3'h0, fc = 3'h0;
	logic [13:0] fl = 14'h0000, jlim = 14'h2328;
	// Port 1 at 100M, port 3 at 1G, the rest at 10M
	logic [15:0] spd = 16'h0084;
	logic [4:0] cc = 5'h00;
	logic awr, wr, bv, arr, rv, vv, va, vs, cd, bpc, fair, nxd, epq, mfl, mfz, itk;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [11:0] vvid;
	logic [2:0] vpr;
	logic [7:0] mr [11];
	int used [8];
	int failures = 0, n_checks = 0, cyc = 0, ntick = 0, tlast = 0, tgap = 0, nfl = 0, k;
	logic [31:0] seed = 32'h4519EAD9, r;
	smgc_top #(.STORM_1G_CYC(20), .INGR_UNIT_CYC(10)) DUT (.sys_clk_in(clk), .rst_in(rst),
		.s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wd),
		.s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr), .s_axi_bresp_out(bresp),
		.s_axi_bvalid_out(bv), .s_axi_bready_in(br), .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv),
		.s_axi_arready_out(arr), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv),
		.s_axi_rready_in(rr), .frm_valid_in(fv), .frm_port_in(fp), .frm_len_in(fl), .frm_tagged_in(ft),
		.frm_bcast_in(fb), .frm_mcast_in(fm), .frm_pause_in(fpa), .frm_vid_in(fvid), .frm_pcp_in(fc),
		.frm_pvid_in(fpv), .jumbo_limit_in(jlim), .port_speed_in(spd), .col_valid_in(cv), .col_count_in(cc),
		.vrd_valid_out(vv), .vrd_accept_out(va), .vrd_storm_drop_out(vs), .vrd_vid_out(vvid),
		.vrd_prio_out(vpr), .col_discard_out(cd), .bp_carrier_sense_out(bpc), .fair_mode_out(fair),
		.no_xcol_drop_out(nxd), .egr_per_queue_out(epq), .mib_flush_out(mfl), .mib_freeze_out(mfz),
		.ingr_tick_out(itk));
	initial begin
		forever #4 clk = ~clk;
	end
	// Tick spacing and flush pulse width are measured here
	always @(posedge clk) begin
		cyc <= rst ? 0 : cyc + 1;
		if (itk === 1'b1) begin
			tgap <= cyc - tlast;
			tlast <= cyc;
			ntick <= ntick + 1;
		end
		if (mfl === 1'b1) begin
			nfl <= nfl + 1;
		end
	end
	// ****************
	// Tasks
	// ****************
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	function automatic bit mp(int i);
		return i >= 0 && i < 11 && i != 6;
	endfunction : mp
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : chk
	task automatic axw(input logic [9:0] idx, input logic [7:0] d);
		bit a, w;
		int i;
		a = 0;
		w = 0;
		i = int'(idx) - 32'h331;
		@(posedge clk);
		awa <= {idx, 2'b00};
		wd <= {24'h000000, d};
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		while (!(a && w)) begin
			@(posedge clk);
			if (awv && awr === 1'b1) a = 1;
			if (wv && wr === 1'b1) w = 1;
			if (a) awv <= 1'b0;
			if (w) wv <= 1'b0;
		end
		do @(posedge clk); while (bv !== 1'b1);
		br <= 1'b0;
		chk("bresp", bresp, mp(i) ? 2'b00 : 2'b10);
		if (mp(i)) mr[i] = d & WM[i];
	endtask : axw
	task automatic axr(input logic [9:0] idx);
		int i;
		i = int'(idx) - 32'h331;
		@(posedge clk);
		ara <= {idx, 2'b00};
		arv <= 1'b1;
		rr <= 1'b1;
		do @(posedge clk); while (arr !== 1'b1);
		arv <= 1'b0;
		do @(posedge clk); while (rv !== 1'b1);
		rr <= 1'b0;
		chk("rdata", rdata, mp(i) ? {24'h000000, mr[i]} : 32'h00000000);
		chk("rresp", rresp, mp(i) ? 2'b00 : 2'b10);
	endtask : axr
	task automatic lv();
		chk("bp_cs", bpc, mr[0][5]);
		chk("fair", fair, mr[0][4]);
		chk("no_xcol", nxd, mr[0][3]);
		chk("egr_q", epq, mr[4][3]);
		chk("freeze", mfz, mr[5][6]);
	endtask : lv
	// Flags are tagged, bcast, mcast, pause; storm use is kept per port in the model
	task automatic frm(input logic [2:0] p, input logic [13:0] l, input logic [3:0] f, input logic [11:0] v,
		input logic [2:0] c);
		int lo, hi, al;
		bit ok, st, sd;
		lo = mr[0][0] ? 32 : 64;
		hi = mr[0][2] ? (jlim > 14'h2328 ? 9000 : int'(jlim)) : (mr[0][1] ? 2000 : (f[3] ? 1522 : 1518));
		al = int'({mr[1][2:0], mr[2]}) * 64;
		ok = l >= lo && l <= hi && (!f[0] || mr[3][0]);
		st = f[2] || (f[1] && !mr[0][6]);
		sd = ok && st && used[p] + l > al;
		if (ok && st && !sd) used[p] += l;
		@(posedge clk);
		fv <= 1'b1;
		{fp, fl, ft, fb, fm, fpa, fvid, fc} <= {p, l, f, v, c};
		fpv <= seed[11:0];
		@(posedge clk);
		fv <= 1'b0;
		#1;
		chk("vrd_valid", vv, 1'b1);
		chk("accept", va, ok && !sd);
		chk("storm", vs, sd);
		chk("vid", vvid, (mr[1][3] && v == 12'h000) ? fpv : v);
		chk("prio", vpr, c[0] ? mr[7 + c / 2][6:4] : mr[7 + c / 2][2:0]);
	endtask : frm
	task automatic end_sim();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_sim
	// ****************
	// Sequence
	// ****************
	initial begin
		repeat (30000) @(posedge clk);
		failures++;
		end_sim();
	end
	initial begin
		foreach (mr[i]) mr[i] = RV[i];
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		lv();
		for (int i = 0; i < 13; i++) axr(10'(i + 32'h330));
		for (int i = 0; i < 13; i++) begin
			axw(10'(i + 32'h330), 8'hFF);
			axr(10'(i + 32'h330));
		end
		chk("flush_count", nfl, 1);
		lv();
		axw(`SMGC_IDX_MIB, 8'h80);
		axr(`SMGC_IDX_MIB);
		chk("flush_count", nfl, 2);
		lv();
		$display("test registers done");
		for (int n = 0; n < 2; n++) begin
			// Alternate back-off lives outside this bank, so only the no-drop bit is set here
			axw(`SMGC_IDX_CTRL1, n ? 8'hF8 : 8'hF0);
			lv();
			foreach (CL[j]) begin
				@(posedge clk);
				cv <= 1'b1;
				cc <= CL[j];
				@(posedge clk);
				cv <= 1'b0;
				#1;
				chk("col_discard", cd, CL[j] >= 5'h10 && n == 0);
			end
		end
		$display("test collisions done");
		// Two fresh ticks after a change, since a shrink cuts the running period short
		for (int c = 0; c < 4; c++) begin
			axw(`SMGC_IDX_CTRL5, {2'b00, 2'(c), 1'(c), 3'b000});
			lv();
			k = ntick;
			while (ntick < k + 2) @(posedge clk);
			chk("ingr_gap", tgap, c == 0 ? 10 : (c == 1 ? 40 : 160));
		end
		$display("test ingress done");
		for (int i = 0; i < 160; i++) begin
			if (i % 16 == 0) begin
				r = xs();
				// Limit settles before the model reads it
				jlim <= 14'(1000 + r % 9000);
				axw(`SMGC_IDX_CTRL1, r[7:0]);
				axw(`SMGC_IDX_CTRL2, r[15:8] & 8'h08);
				axw(`SMGC_IDX_CTRL4, r[23:16]);
				axw(10'(r[25:24] + 32'h338), r[31:24]);
				lv();
			end
			r = xs();
			k = r[3:0] < 12 ? LT[r[3:0]] : (r[3:0] == 12 ? int'(jlim) : (r[3:0] == 13 ? jlim + 1 : r[29:16]));
			frm(r[6:4], 14'(k), {r[7], 2'b00, r[8]}, r[9] ? 12'h000 : r[21:10], r[24:22]);
		end
		$display("test frames done");
		jlim <= 14'h2328;
		axw(`SMGC_IDX_CTRL1, 8'hF4);
		axw(`SMGC_IDX_CTRL2, 8'h01);
		axw(`SMGC_IDX_CTRL3, 8'h00);
		// Bursts start mid period so no restart lands inside them
		while (cyc % 2000 != 100) @(posedge clk);
		frm(3'h2, 14'h2328, 4'h4, 12'h001, 3'h0);
		frm(3'h2, 14'h2328, 4'h4, 12'h001, 3'h0);
		axw(`SMGC_IDX_CTRL2, 8'h00);
		axw(`SMGC_IDX_CTRL3, 8'h01);
		for (int i = 0; i < 3; i++) frm(3'h0, 14'h0040, i < 2 ? 4'h4 : 4'h2, 12'h005, 3'h1);
		axw(`SMGC_IDX_CTRL1, 8'hB4);
		frm(3'h0, 14'h0040, 4'h2, 12'h005, 3'h1);
		frm(3'h1, 14'h0040, 4'h4, 12'h005, 3'h2);
		frm(3'h1, 14'h0040, 4'h4, 12'h005, 3'h2);
		repeat (300) @(posedge clk);
		used[1] = 0;
		frm(3'h1, 14'h0040, 4'h4, 12'h005, 3'h2);
		frm(3'h0, 14'h0040, 4'h4, 12'h005, 3'h2);
		while (cyc % 2000 != 150) @(posedge clk);
		used = '{default: 0};
		frm(3'h0, 14'h0040, 4'h4, 12'h005, 3'h3);
		// 1G port: both frames inside one short period, then one after a restart
		while (cyc % 20 != 5) @(posedge clk);
		frm(3'h3, 14'h0040, 4'h4, 12'h005, 3'h4);
		frm(3'h3, 14'h0040, 4'h4, 12'h005, 3'h4);
		repeat (20) @(posedge clk);
		used[3] = 0;
		frm(3'h3, 14'h0040, 4'h4, 12'h005, 3'h4);
		$display("test storm done");
		end_sim();
	end
endmodule : switch_mac_global_control_tb_top
